/* logic/lmt_map.svh */
// Register offsets, field positions, reset values and fixed counts of the tuning bank.
`ifndef LMT_MAP_SVH
`define LMT_MAP_SVH

// Word indices of the register halves; the byte address is four times the index.
`define LMT_IDX_TUNE_LO 3'h0
`define LMT_IDX_TUNE_HI 3'h1
`define LMT_IDX_OPEN_LO 3'h2
`define LMT_IDX_OPEN_HI 3'h3
`define LMT_IDX_SHORT_LO 3'h4
`define LMT_IDX_SHORT_HI 3'h5

// Tuning register reset value and the mask of its writable bits.
`define LMT_TUNE_RESET 48'h0800_0540_403C
`define LMT_TUNE_RW_MASK 48'h1FFF_0FFF_4002

// Tuning register field positions.
`define LMT_BIT_MAX_CHANNEL_CURRENT_SELECT 1
`define LMT_BIT_SCAN_ORDER_REVERSE 14
`define LMT_BIT_FINE_LSB 16
`define LMT_BIT_OFF_LSB 19
`define LMT_BIT_ON_LSB 22
`define LMT_BIT_COARSE_LSB 32
`define LMT_BIT_DIM_LSB 35
`define LMT_BIT_ISO_EN 39
`define LMT_BIT_BOOST_LSB 40
`define LMT_BIT_BOOST_EN 44

// Locate selector width and reset.
`define LMT_LOCATE_W 6
`define LMT_LOCATE_RESET 6'h00

// Channel current limits in milliamperes.
`define LMT_MAX_CHANNEL_CURRENT_SELECT_LOW_MA 5'h0A
`define LMT_MAX_CHANNEL_CURRENT_SELECT_HIGH_MA 5'h14

// Scan lines per half of a stacked pair.
`define LMT_HALF_LINES 6'h10
`define LMT_REV_BASE 6'h2F

`endif

/* logic/lmt_pkg.sv */
// Types shared by the tuning register bank modules.
package lmt_pkg;
  typedef enum logic [1:0] {
    LMT_BUS_IDLE = 2'b00,
    LMT_BUS_ACK = 2'b01,
    LMT_BUS_HOLD = 2'b11
  } lmt_bus_state_t;

  typedef enum logic [1:0] {
    LMT_SLEW_SLOWEST = 2'b00,
    LMT_SLEW_SLOW = 2'b01,
    LMT_SLEW_FAST = 2'b10,
    LMT_SLEW_FASTEST = 2'b11
  } lmt_slew_t;
endpackage

/* logic/lmt_bus_if.sv */
// Internal carrier between the bus slave and the register storage.
`timescale 1ns/1ns
interface lmt_bus_if;
  logic wr_stb;
  logic [2:0] idx;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;

  modport slave (output wr_stb, output idx, output wdata, output be, input rdata);
  modport regs (input wr_stb, input idx, input wdata, input be, output rdata);
endinterface

/* logic/lmt_avs_slave.sv */
// Avalon-MM slave answering after one wait cycle, feeding the register storage.
`timescale 1ns/1ns
`include "lmt_map.svh"
module lmt_avs_slave
  import lmt_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Avalon-MM slave.
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Register side.
  lmt_bus_if.slave bus
);
  lmt_bus_state_t state_r;
  lmt_bus_state_t state_nxt;
  logic [31:0] readdata_r;
  wire req = avs_read_in | avs_write_in;

  // The hold state covers the cycle in which the registered answer stands at the pins,
  // so a request that is still held then is not taken a second time.
  assign state_nxt = (state_r == LMT_BUS_IDLE && req) ? LMT_BUS_ACK :
                     (state_r == LMT_BUS_ACK) ? LMT_BUS_HOLD : LMT_BUS_IDLE;
  assign bus.idx = avs_address_in[4:2];
  assign bus.wdata = avs_writedata_in;
  assign bus.be = avs_byteenable_in;
  // The write lands one edge before the master sees waitrequest low at the registered pins.
  assign bus.wr_stb = (state_r == LMT_BUS_ACK) & avs_write_in;
  assign avs_readdata_out = readdata_r;
  assign avs_waitrequest_out = (state_r != LMT_BUS_ACK);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_r <= LMT_BUS_IDLE;
      readdata_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == LMT_BUS_IDLE && avs_read_in)
        readdata_r <= bus.rdata;
    end
  end
endmodule

/* logic/lmt_locate_reg.sv */
// Six-bit scan line selector held in the low lane of a locate register.
`timescale 1ns/1ns
`include "lmt_map.svh"
module lmt_locate_reg #(
  parameter int WIDTH = `LMT_LOCATE_W
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Write port.
  input wire logic wr_in,
  input wire logic lane0_in,
  input wire logic [WIDTH-1:0] wdata_in,
  // Selected line.
  output logic [WIDTH-1:0] sel_out
);
  initial
  begin
    if (WIDTH < 1 || WIDTH > 8)
      $error("Locate width must fit the low byte lane.");
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      sel_out <= WIDTH'(`LMT_LOCATE_RESET);
    else if (wr_in && lane0_in)
      sel_out <= wdata_in;
  end
endmodule

/* logic/lmt_tuning_regs.sv */
// Tuning and line-locate register bank of the LED matrix driver.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "lmt_map.svh"
module lmt_tuning_regs
  import lmt_pkg::*;
#(
  parameter int LINE_W = 6
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Avalon-MM slave.
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Current and scan order.
  output logic max_channel_current_select_out,
  output logic [4:0] max_current_ma_out,
  output logic scan_order_reverse_out,
  input wire logic [LINE_W-2:0] scan_step_in,
  output logic [LINE_W-2:0] scan_line_out,
  // Compensation and edge speeds, red in bit 0.
  output logic [2:0] fine_range_enable_out,
  output logic [2:0] coarse_range_enable_out,
  output logic [2:0] turnoff_edge_speed_out,
  output lmt_slew_t red_turnon_edge_speed_out,
  output lmt_slew_t green_turnon_edge_speed_out,
  output lmt_slew_t blue_turnon_edge_speed_out,
  // Dimming and isolation.
  output logic [4:0] first_line_dim_level_out,
  output logic on_off_channel_isolation_enable_out,
  output logic [4:0] isolation_boost_applied_out,
  // Diagnostic line selectors.
  output logic [5:0] open_load_row_select_out,
  output logic [5:0] short_row_select_out
);
  initial
  begin
    if (LINE_W != 6)
      $error("Scan line mapping serves 32 lines over 64 addresses only.");
  end

  lmt_bus_if bus ();
  logic [31:0] avs_readdata_w;
  logic avs_waitrequest_w;
  logic [47:0] tune_r;
  logic [47:0] tune_nxt;
  logic [5:0] open_sel;
  logic [5:0] short_sel;
  logic [4:0] max_ma_r;
  logic [4:0] dim_lvl_r;
  logic [4:0] boost_r;
  logic [LINE_W-2:0] scan_line_r;
  logic [31:0] readdata_r;
  logic waitreq_r;

  lmt_avs_slave u_slave (
    .clk_in(sys_clk_in),
    .rst_in(rst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_w),
    .avs_waitrequest_out(avs_waitrequest_w),
    .bus(bus)
  );

  // Byte-lane merge of the tuning register halves.
  wire [31:0] lane_mask = {{8{bus.be[3]}}, {8{bus.be[2]}}, {8{bus.be[1]}}, {8{bus.be[0]}}};
  wire wr_tune_lo = bus.wr_stb && bus.idx == `LMT_IDX_TUNE_LO;
  wire wr_tune_hi = bus.wr_stb && bus.idx == `LMT_IDX_TUNE_HI;
  wire [31:0] lo_merge = (tune_r[31:0] & ~lane_mask) | (bus.wdata & lane_mask);
  wire [15:0] hi_merge = (tune_r[47:32] & ~lane_mask[15:0]) | (bus.wdata[15:0] & lane_mask[15:0]);
  wire [47:0] tune_wr = {wr_tune_hi ? hi_merge : tune_r[47:32],
                         wr_tune_lo ? lo_merge : tune_r[31:0]};
  // Reserved bits are rebuilt from the reset pattern on every write.
  assign tune_nxt = (tune_wr & `LMT_TUNE_RW_MASK) | (`LMT_TUNE_RESET & ~`LMT_TUNE_RW_MASK);

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      tune_r <= `LMT_TUNE_RESET;
    else
      tune_r <= tune_nxt;
  end

  lmt_locate_reg #(
    .WIDTH(6)
  ) u_open_loc (
    .clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_in(bus.wr_stb && bus.idx == `LMT_IDX_OPEN_LO),
    .lane0_in(bus.be[0]),
    .wdata_in(bus.wdata[5:0]),
    .sel_out(open_sel)
  );

  lmt_locate_reg #(
    .WIDTH(6)
  ) u_short_loc (
    .clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_in(bus.wr_stb && bus.idx == `LMT_IDX_SHORT_LO),
    .lane0_in(bus.be[0]),
    .wdata_in(bus.wdata[5:0]),
    .sel_out(short_sel)
  );

  // Read mux; the upper halves of the locate registers and unmapped words read zero.
  wire [31:0] rd_open = {26'h0000000, open_sel};
  wire [31:0] rd_short = {26'h0000000, short_sel};
  assign bus.rdata = (bus.idx == `LMT_IDX_TUNE_LO) ? tune_r[31:0] :
                     (bus.idx == `LMT_IDX_TUNE_HI) ? {16'h0000, tune_r[47:32]} :
                     (bus.idx == `LMT_IDX_OPEN_LO) ? rd_open :
                     (bus.idx == `LMT_IDX_SHORT_LO) ? rd_short : 32'h0000_0000;

  // Field decode.
  wire max_channel_current_select_bit = tune_r[`LMT_BIT_MAX_CHANNEL_CURRENT_SELECT];
  wire rev_bit = tune_r[`LMT_BIT_SCAN_ORDER_REVERSE];
  wire [3:0] dim_code = tune_r[`LMT_BIT_DIM_LSB +: 4];
  wire [3:0] boost_code = tune_r[`LMT_BIT_BOOST_LSB +: 4];
  wire boost_en = tune_r[`LMT_BIT_BOOST_EN];
  wire [4:0] max_ma_nxt = max_channel_current_select_bit ? `LMT_MAX_CHANNEL_CURRENT_SELECT_HIGH_MA : `LMT_MAX_CHANNEL_CURRENT_SELECT_LOW_MA;
  wire [4:0] dim_lvl_nxt = {1'b0, dim_code} + 5'h01;
  wire [4:0] boost_nxt = boost_en ? ({1'b0, boost_code} + 5'h01) : 5'h00;
  // The upper half of a stacked pair runs backwards when reversed.
  wire upper_half = scan_step_in >= `LMT_HALF_LINES;
  wire [LINE_W-2:0] rev_line = 5'(`LMT_REV_BASE - {1'b0, scan_step_in});
  wire [LINE_W-2:0] scan_line_nxt = (rev_bit && upper_half) ? rev_line : scan_step_in;

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      max_ma_r <= `LMT_MAX_CHANNEL_CURRENT_SELECT_LOW_MA;
      dim_lvl_r <= 5'h01;
      boost_r <= 5'h00;
      scan_line_r <= 5'h00;
      readdata_r <= 32'h0000_0000;
      waitreq_r <= 1'b1;
    end
    else
    begin
      max_ma_r <= max_ma_nxt;
      dim_lvl_r <= dim_lvl_nxt;
      boost_r <= boost_nxt;
      scan_line_r <= scan_line_nxt;
      readdata_r <= avs_readdata_w;
      waitreq_r <= avs_waitrequest_w;
    end
  end

  // The bus answers are carried one stage so that every output leaves a flip-flop.
  assign avs_readdata_out = readdata_r;
  assign avs_waitrequest_out = waitreq_r;
  assign max_channel_current_select_out = max_channel_current_select_bit;
  assign max_current_ma_out = max_ma_r;
  assign scan_order_reverse_out = rev_bit;
  assign scan_line_out = scan_line_r;
  assign fine_range_enable_out = tune_r[`LMT_BIT_FINE_LSB +: 3];
  assign coarse_range_enable_out = tune_r[`LMT_BIT_COARSE_LSB +: 3];
  assign turnoff_edge_speed_out = tune_r[`LMT_BIT_OFF_LSB +: 3];
  assign red_turnon_edge_speed_out = lmt_slew_t'(tune_r[`LMT_BIT_ON_LSB +: 2]);
  assign green_turnon_edge_speed_out = lmt_slew_t'(tune_r[`LMT_BIT_ON_LSB + 2 +: 2]);
  assign blue_turnon_edge_speed_out = lmt_slew_t'(tune_r[`LMT_BIT_ON_LSB + 4 +: 2]);
  assign first_line_dim_level_out = dim_lvl_r;
  assign on_off_channel_isolation_enable_out = tune_r[`LMT_BIT_ISO_EN];
  assign isolation_boost_applied_out = boost_r;
  assign open_load_row_select_out = open_sel;
  assign short_row_select_out = short_sel;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence tune_lo_write_s;
    bus.wr_stb && bus.idx == `LMT_IDX_TUNE_LO && bus.be[0] && bus.be[1];
  endsequence

  sequence tune_hi_write_s;
    bus.wr_stb && bus.idx == `LMT_IDX_TUNE_HI && bus.be[0] && bus.be[1];
  endsequence

  max_channel_current_select_current_a: assert property (tune_lo_write_s |=> ##1
      max_current_ma_out == ($past(bus.wdata[1], 2) ? 5'h14 : 5'h0A))
    else $error("Current ceiling does not follow the written select bit.");

  scan_order_reverse_store_a: assert property (tune_lo_write_s |=>
      scan_order_reverse_out == $past(bus.wdata[14]))
    else $error("Scan reverse bit not stored.");

  scan_order_reverse_map_a: assert property (scan_order_reverse_out && scan_step_in == 5'h10 |=>
      scan_line_out == 5'h1F)
    else $error("Reversed upper half does not start at the last line.");

  fine_enable_a: assert property (
      bus.wr_stb && bus.idx == `LMT_IDX_TUNE_LO && bus.be[2] |=>
      fine_range_enable_out == $past(bus.wdata[18:16]))
    else $error("Fine range enables not stored.");

  off_speed_a: assert property (
      bus.wr_stb && bus.idx == `LMT_IDX_TUNE_LO && bus.be[2] |=>
      turnoff_edge_speed_out == $past(bus.wdata[21:19]))
    else $error("Turn-off edge speeds not stored.");

  on_speed_a: assert property (
      bus.wr_stb && bus.idx == `LMT_IDX_TUNE_LO && bus.be[3] && bus.be[2] |=>
      blue_turnon_edge_speed_out == lmt_slew_t'($past(bus.wdata[27:26])))
    else $error("Blue turn-on edge code not stored.");

  coarse_enable_a: assert property (tune_hi_write_s |=>
      coarse_range_enable_out == $past(bus.wdata[2:0]))
    else $error("Coarse range enables not stored.");

  dim_level_a: assert property (tune_hi_write_s |=> ##1
      first_line_dim_level_out == {1'b0, $past(bus.wdata[6:3], 2)} + 5'h01)
    else $error("First line dim level is not code plus one.");

  isolation_en_a: assert property (tune_hi_write_s |=>
      on_off_channel_isolation_enable_out == $past(bus.wdata[7]))
    else $error("Isolation enable not stored.");

  boost_gate_a: assert property ((tune_hi_write_s and !bus.wdata[12]) |=> ##1
      isolation_boost_applied_out == 5'h00)
    else $error("Boost level applied while disabled.");

  open_locate_a: assert property (
      bus.wr_stb && bus.idx == `LMT_IDX_OPEN_LO && bus.be[0] |=>
      open_load_row_select_out == $past(bus.wdata[5:0]))
    else $error("Open-load line selector not stored.");

  short_locate_a: assert property (
      bus.wr_stb && bus.idx == `LMT_IDX_SHORT_LO && bus.be[0] |=>
      short_row_select_out == $past(bus.wdata[5:0]))
    else $error("Short line selector not stored.");

  reserved_fixed_a: assert property (
      (tune_r & ~`LMT_TUNE_RW_MASK) == (`LMT_TUNE_RESET & ~`LMT_TUNE_RW_MASK))
    else $error("Reserved tuning bits left their fixed pattern.");

  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("Waitrequest low for more than one cycle.");

  wait_gap_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out [*2])
    else $error("Second answer given to a request that was already answered.");

  red_on_speed_a: assert property (
      bus.wr_stb && bus.idx == `LMT_IDX_TUNE_LO && bus.be[2] |=>
      red_turnon_edge_speed_out == lmt_slew_t'($past(bus.wdata[23:22])))
    else $error("Red turn-on edge code not stored.");

  green_on_speed_a: assert property (
      bus.wr_stb && bus.idx == `LMT_IDX_TUNE_LO && bus.be[3] |=>
      green_turnon_edge_speed_out == lmt_slew_t'($past(bus.wdata[25:24])))
    else $error("Green turn-on edge code not stored.");

  boost_level_a: assert property ((tune_hi_write_s and bus.wdata[12]) |=> ##1
      isolation_boost_applied_out == {1'b0, $past(bus.wdata[11:8], 2)} + 5'h01)
    else $error("Boost level is not code plus one while enabled.");

  scan_fwd_a: assert property (
      !scan_order_reverse_out |=> scan_line_out == $past(scan_step_in))
    else $error("Scan line does not follow the step with reversal off.");

  open_hold_a: assert property (
      !(bus.wr_stb && bus.idx == `LMT_IDX_OPEN_LO) |=> $stable(open_load_row_select_out))
    else $error("Open-load line selector changed without a write.");

  short_hold_a: assert property (
      !(bus.wr_stb && bus.idx == `LMT_IDX_SHORT_LO) |=> $stable(short_row_select_out))
    else $error("Short line selector changed without a write.");

  high_half_zero_a: assert property (
      bus.idx == `LMT_IDX_OPEN_HI || bus.idx == `LMT_IDX_SHORT_HI |->
      bus.rdata == 32'h0000_0000)
    else $error("Locate high half does not read zero.");
endmodule

/* verif/lmt_host_model.sv */
// Avalon-MM host model that issues single register accesses.
`timescale 1ns/1ns
module lmt_host_model (
  // Clock.
  input wire logic clk_in,
  // Avalon-MM master side.
  output logic [4:0] avs_address_out,
  output logic avs_read_out,
  output logic avs_write_out,
  output logic [31:0] avs_writedata_out,
  output logic [3:0] avs_byteenable_out,
  input wire logic [31:0] avs_readdata_in,
  input wire logic avs_waitrequest_in
);
  initial
  begin
    avs_address_out = 5'h00;
    avs_read_out = 1'b0;
    avs_write_out = 1'b0;
    avs_writedata_out = 32'h0;
    avs_byteenable_out = 4'h0;
  end

  // The request stands until waitrequest is sampled low or 50 cycles pass, and the data lines
  // show the inverse afterwards so that no stale value looks valid.
  task automatic access(input logic w, input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] b, output logic [31:0] r, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    r = 32'h0;
    @(posedge clk_in);
    avs_address_out <= a;
    avs_read_out <= !w;
    avs_write_out <= w;
    avs_writedata_out <= d;
    avs_byteenable_out <= b;
    while (n < 50 && !ok)
    begin
      @(posedge clk_in);
      n++;
      if (avs_waitrequest_in === 1'b0)
      begin
        ok = 1'b1;
        r = avs_readdata_in;
      end
    end
    avs_read_out <= 1'b0;
    avs_write_out <= 1'b0;
    avs_writedata_out <= ~d;
  endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the tuning and line-locate register bank.
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {logic [4:0] a; logic [31:0] d; logic [3:0] b; logic [31:0] e;} lmt_row_t;
  logic sys_clk_in, rst_in, rd, wr, wt, isel, rev, iso;
  logic [4:0] addr, ma, line, dim, boost, step;
  logic [31:0] wd, rdat;
  logic [3:0] be;
  logic [2:0] fine, coarse, toff;
  logic [1:0] on_r, on_g, on_b;
  logic [5:0] osel, ssel, open_s, short_s;
  logic [47:0] tune;
  int errors, compares;
  lmt_row_t rows [16] = '{
    '{5'h00, 32'hFFFF_FFFF, 4'hF, 32'h0FFF_403E}, '{5'h04, 32'hFFFF_FFFF, 4'hF, 32'h0000_1FFF},
    '{5'h00, 32'h0000_0000, 4'hF, 32'h0000_003C}, '{5'h04, 32'h0000_0000, 4'hF, 32'h0000_0000},
    '{5'h04, 32'h0000_0A5A, 4'h2, 32'h0000_0A00}, '{5'h04, 32'hFFFF_FF95, 4'h1, 32'h0000_0A95},
    '{5'h04, 32'h0000_1A95, 4'h3, 32'h0000_1A95}, '{5'h00, 32'h0AAA_0000, 4'hC, 32'h0AAA_003C},
    '{5'h00, 32'h0000_4002, 4'h1, 32'h0AAA_003E}, '{5'h00, 32'h0555_4000, 4'h6, 32'h0A55_403E},
    '{5'h08, 32'hFFFF_FFFF, 4'hF, 32'h0000_003F}, '{5'h10, 32'hFFFF_FFA5, 4'h1, 32'h0000_0025},
    '{5'h10, 32'h0000_0011, 4'h2, 32'h0000_0025}, '{5'h0C, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000},
    '{5'h18, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000}, '{5'h0B, 32'h0000_0001, 4'hF, 32'h0000_0001}};

  lmt_host_model host (.clk_in(sys_clk_in), .avs_address_out(addr), .avs_read_out(rd),
    .avs_write_out(wr), .avs_writedata_out(wd), .avs_byteenable_out(be),
    .avs_readdata_in(rdat), .avs_waitrequest_in(wt));

  lmt_tuning_regs uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .max_channel_current_select_out(isel),
    .max_current_ma_out(ma), .scan_order_reverse_out(rev), .scan_step_in(step),
    .scan_line_out(line), .fine_range_enable_out(fine), .coarse_range_enable_out(coarse),
    .turnoff_edge_speed_out(toff), .red_turnon_edge_speed_out(on_r),
    .green_turnon_edge_speed_out(on_g), .blue_turnon_edge_speed_out(on_b),
    .first_line_dim_level_out(dim), .on_off_channel_isolation_enable_out(iso),
    .isolation_boost_applied_out(boost), .open_load_row_select_out(osel),
    .short_row_select_out(ssel));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] b, output logic [31:0] r);
    logic ok;
    host.access(w, a, d, b, r, ok);
    if (ok !== 1'b1)
    begin
      errors++;
      $display("ERROR waitrequest expected 0 seen 1");
      end_sim();
    end
  endtask

  // Compares every field output with the bench's copy of the registers.
  task automatic check_outs(input logic [4:0] s);
    logic [4:0] ln;
    step <= s;
    ln = (s < 5'h10 || !tune[14]) ? s : 5'(6'd47 - {1'b0, s});
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk("current_sel", tune[1], isel);
    chk("current_ma", tune[1] ? 5'h14 : 5'h0A, ma);
    chk("scan_order_reverse", tune[14], rev);
    chk("scan_line", ln, line);
    chk("fine", tune[18:16], fine);
    chk("turnoff", tune[21:19], toff);
    chk("turnon", tune[27:22], {on_b, on_g, on_r});
    chk("coarse", tune[34:32], coarse);
    chk("dim", {1'b0, tune[38:35]} + 5'h01, dim);
    chk("iso", tune[39], iso);
    chk("boost", tune[44] ? {1'b0, tune[43:40]} + 5'h01 : 5'h00, boost);
    chk("open_sel", open_s, osel);
    chk("short_sel", short_s, ssel);
  endtask

  task automatic reset_reads();
    logic [31:0] r;
    tune = 48'h0800_0540_403C;
    open_s = 6'h00;
    short_s = 6'h00;
    check_outs(5'h10);
    bus(1'b0, 5'h00, 32'h0, 4'hF, r);
    chk("tune_lo_reset", 32'h0540_403C, r);
    bus(1'b0, 5'h04, 32'h0, 4'hF, r);
    chk("tune_hi_reset", 32'h0000_0800, r);
    bus(1'b0, 5'h08, 32'h0, 4'hF, r);
    chk("open_reset", 32'h0, r);
    bus(1'b0, 5'h10, 32'h0, 4'hF, r);
    chk("short_reset", 32'h0, r);
    $display("reset test done");
  endtask

  initial
  begin
    logic [31:0] r;
    errors = 0;
    compares = 0;
    rst_in = 1'b1;
    step = 5'h00;
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    reset_reads();
    for (int i = 0; i < 16; i++)
    begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].b, r);
      bus(1'b0, rows[i].a, 32'h0, 4'hF, r);
      chk("readback", rows[i].e, r);
      case (rows[i].a[4:2])
        3'h0: tune[31:0] = rows[i].e;
        3'h1: tune[47:32] = rows[i].e[15:0];
        3'h2: open_s = rows[i].e[5:0];
        3'h4: short_s = rows[i].e[5:0];
        default: ;
      endcase
      check_outs(5'(i * 7));
      $display("test %0d done", i);
    end
    // A second reset in mid-run must bring back every reset value.
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    reset_reads();
    end_sim();
  end
endmodule
